// ---- design/ulpw_buf2.sv ----
// Two-entry valid/ready buffer for received frames
`timescale 1ns/1ps
module ulpw_buf2
    import ulpw_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input ulpw_pkg::ulpw_frame_t in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output ulpw_pkg::ulpw_frame_t out_data_o
);
    import ulpw_pkg::*;

    typedef struct packed {
        ulpw_frame_t [1:0] mem;
        logic [1:0] cnt;
        logic rp;
        logic wp;
    } ulpw_buf_st_t;
    ulpw_buf_st_t s_q, s_d;
    logic push, pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready_o = (s_q.cnt != 2'h2);
    assign out_valid_o = (s_q.cnt != 2'h0);
    assign out_data_o = s_q.mem[s_q.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Next state
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data_i;
            s_d.wp = ~s_q.wp;
        end
        if (pop)
            s_d.rp = ~s_q.rp;
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    a_buf_no_overfill: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.cnt <= 2'h2) else $error("buffer count above two");
endmodule // ulpw_buf2

// ---- design/ulpw_pkg.sv ----
// Package for the low-power wake receiver: register map, fields, timing
package ulpw_pkg;
    // Register offsets (byte addresses, word aligned)
    localparam logic [7:0] ULPW_OFF_CTRL = 8'h00;
    localparam logic [7:0] ULPW_OFF_BAUD = 8'h04;
    localparam logic [7:0] ULPW_OFF_STAT = 8'h08;
    localparam logic [7:0] ULPW_OFF_DATA = 8'h0c;
    localparam logic [7:0] ULPW_OFF_CHAN = 8'h10;
    // Control register fields
    localparam int ULPW_CTRL_WAKE_EN = 0;
    localparam int ULPW_CTRL_ERR_MASK = 1;
    localparam int ULPW_CTRL_ERR_IRQ_EN = 2;
    localparam int ULPW_CTRL_CH1_START = 3;
    localparam int ULPW_CTRL_PARITY_EN = 4;
    // Status register fields (write 1 to clear the error flags)
    localparam int ULPW_STAT_PE = 0;
    localparam int ULPW_STAT_FE = 1;
    localparam int ULPW_STAT_OV = 2;
    localparam int ULPW_STAT_BUSY = 3;
    localparam int ULPW_STAT_AVAIL = 4;
    // Baud register: prescaler exponent in [3:0], divisor in [15:9]
    localparam int ULPW_BAUD_DIV_LSB = 9;
    localparam int ULPW_BAUD_DIV_MSB = 15;
    localparam logic [31:0] ULPW_BAUD_RESET = 32'h0000d205;
    // Channel this wake function belongs to
    localparam logic [1:0] ULPW_WAKE_CHANNEL = 2'h0;
    // Frame and rate
    localparam int ULPW_WAKE_BPS = 4800;
    localparam int ULPW_DATA_BITS = 8;
    // Bus and frame carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ulpw_bus_req_t;
    typedef struct packed {
        logic [7:0] data;
        logic pe;
        logic fe;
    } ulpw_frame_t;
endpackage

// ---- design/ulpw_wake_rx.sv ----
// Wake-on-receive serial receiver for channel 0 with a register port
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module ulpw_wake_rx
    import ulpw_pkg::*;
#(
    parameter logic [1:0] CHANNEL_ID = 2'h0
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Chip power state
    input wire logic stop_mode_i,
    // Serial pin
    input wire logic serial_rx_pin_i,
    // Events
    output logic rx_complete_irq_o,
    output logic rx_error_irq_o
);
    import ulpw_pkg::*;

    // Elaboration check: the shift register and data field serve 8-bit frames only
    if (ULPW_DATA_BITS != 8)
    begin : g_bad_width
        $error("receiver serves 8 data bits only");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b11,
        ST_STOP = 2'b10
    } ulpw_state_t;

    typedef struct packed {
        logic [2:0] sync;
        ulpw_state_t st;
        logic [15:0] tick;
        logic [3:0] bitn;
        logic [8:0] shreg;
        logic [4:0] ctrl;
        logic [31:0] baud;
        logic pe;
        logic fe;
        logic ov;
        logic [7:0] data;
        logic avail;
        logic in_stop_start;
        logic cplt;
        logic err;
        logic [31:0] rdata;
    } ulpw_st_t;

    ulpw_st_t s_q, s_d;
    ulpw_frame_t fr_in, fr_out;
    logic fr_valid, fr_ready, out_valid, out_ready;
    logic rx, wake_allowed, running, bit_period_end, half_end;
    logic [15:0] period;

    // Bit period from prescaler exponent and divisor: (div+1) << exp
    function automatic logic [15:0] bit_cycles(input logic [31:0] b);
        logic [15:0] d;
        d = {9'h0, b[ULPW_BAUD_DIV_MSB:ULPW_BAUD_DIV_LSB]} + 16'h1;
        return 16'(d << b[3:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Derived controls
    assign rx = s_q.sync[2];
    assign wake_allowed = (CHANNEL_ID == ULPW_WAKE_CHANNEL);
    // Halted in stop unless wake armed; ch1 start gates the receiver state machine
    assign running = s_q.ctrl[ULPW_CTRL_CH1_START] && (!stop_mode_i ||
        (wake_allowed && s_q.ctrl[ULPW_CTRL_WAKE_EN]));
    // Divisor and prescaler give 4800 bps only as software sets them
    assign period = bit_cycles(s_q.baud);
    assign bit_period_end = (s_q.tick >= period - 16'h1);
    assign half_end = (s_q.tick >= {1'b0, period[15:1]});
    assign fr_in.data = s_q.shreg[7:0];
    assign fr_in.pe = s_q.ctrl[ULPW_CTRL_PARITY_EN] && (^s_q.shreg);
    // A frame begun outside stop with wake armed cannot be trusted: flag it corrupt
    assign fr_in.fe = !rx || (s_q.ctrl[ULPW_CTRL_WAKE_EN] && !s_q.in_stop_start);
    assign fr_valid = (s_q.st == ST_STOP) && bit_period_end;
    assign out_ready = !s_q.avail;

    ////////////////////////////////////////////////////////////////////////
    // Frame buffer: holds two frames behind the data register; a frame arriving when it is full is dropped
    ulpw_buf2 u_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(fr_valid),
        .in_ready_o(fr_ready),
        .in_data_i(fr_in),
        .out_valid_o(out_valid),
        .out_ready_i(out_ready),
        .out_data_o(fr_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], serial_rx_pin_i};
        s_d.cplt = 1'b0;
        s_d.err = 1'b0;
        s_d.rdata = 32'h0;
        s_d.tick = s_q.tick + 16'h1;
        // Receiver
        case (s_q.st)
            ST_IDLE:
            begin
                s_d.tick = 16'h0;
                if (running && !rx)
                begin
                    s_d.st = ST_START;
                    s_d.in_stop_start = stop_mode_i;
                end
            end
            ST_START:
                if (half_end)
                begin
                    s_d.tick = 16'h0;
                    s_d.bitn = 4'h0;
                    s_d.st = rx ? ST_IDLE : ST_DATA;
                end
            ST_DATA:
                if (bit_period_end)
                begin
                    s_d.tick = 16'h0;
                    s_d.shreg = {rx, s_q.shreg[8:1]};
                    s_d.bitn = s_q.bitn + 4'h1;
                    if (s_q.bitn == (s_q.ctrl[ULPW_CTRL_PARITY_EN] ? 4'h8 : 4'h7))
                    begin
                        s_d.st = ST_STOP;
                        if (!s_q.ctrl[ULPW_CTRL_PARITY_EN])
                            s_d.shreg = {1'b0, rx, s_q.shreg[8:2]};
                    end
                end
            ST_STOP:
                if (bit_period_end)
                    s_d.st = ST_IDLE;
            default:
                s_d.st = ST_IDLE;
        endcase
        // Register writes first; error flags are write-one-to-clear
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ULPW_OFF_CTRL: s_d.ctrl = reg_wdata_i[4:0];
                ULPW_OFF_BAUD: s_d.baud = reg_wdata_i;
                ULPW_OFF_STAT:
                begin
                    if (reg_wdata_i[ULPW_STAT_PE]) s_d.pe = 1'b0;
                    if (reg_wdata_i[ULPW_STAT_FE]) s_d.fe = 1'b0;
                    if (reg_wdata_i[ULPW_STAT_OV]) s_d.ov = 1'b0;
                end
                default: ;
            endcase
        end
        // Completed frame leaves buffer into the data register; sets after the clear win
        if (out_valid && out_ready)
        begin
            s_d.data = fr_out.data;
            s_d.avail = 1'b1;
            if ((fr_out.pe || fr_out.fe) && !s_q.ctrl[ULPW_CTRL_ERR_MASK])
            begin
                s_d.pe = s_d.pe | fr_out.pe;
                s_d.fe = s_d.fe | fr_out.fe;
                s_d.err = s_q.ctrl[ULPW_CTRL_ERR_IRQ_EN];
            end
            else if (!(fr_out.pe || fr_out.fe))
                s_d.cplt = 1'b1;
        end
        // Frame dropped for a full buffer is an overrun
        if (fr_valid && !fr_ready && !s_q.ctrl[ULPW_CTRL_ERR_MASK])
        begin
            s_d.ov = 1'b1;
            s_d.err = s_q.ctrl[ULPW_CTRL_ERR_IRQ_EN];
        end
        // Register reads; data read frees the data register
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ULPW_OFF_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
                ULPW_OFF_BAUD: s_d.rdata = s_q.baud;
                ULPW_OFF_STAT: s_d.rdata = {27'h0, s_q.avail, s_q.st != ST_IDLE,
                    s_q.ov, s_q.fe, s_q.pe};
                ULPW_OFF_DATA:
                begin
                    s_d.rdata = {24'h0, s_q.data};
                    if (!(out_valid && out_ready))
                        s_d.avail = 1'b0;
                end
                ULPW_OFF_CHAN: s_d.rdata = {30'h0, CHANNEL_ID};
                default: s_d.rdata = 32'h0;
            endcase
        end
        // Halt forces receiver back to idle
        if (!running)
            s_d.st = ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
            s_q.sync <= 3'h7;
            s_q.baud <= ULPW_BAUD_RESET;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata_o = s_q.rdata;
    assign rx_complete_irq_o = s_q.cplt;
    assign rx_error_irq_o = s_q.err;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_halt_in_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
        stop_mode_i && !s_q.ctrl[ULPW_CTRL_WAKE_EN] |=> s_q.st == ST_IDLE)
        else $error("receiver active in stop without wake");
    a_wake_launch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == ST_IDLE && running && !rx |=> s_q.st == ST_START)
        else $error("start edge did not launch reception");
    a_mask_no_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(s_q.ctrl[ULPW_CTRL_ERR_MASK]) |->
        !$rose(s_q.fe) && !$rose(s_q.pe) && !$rose(s_q.ov))
        else $error("error flag set while masked");
    a_mask_no_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(s_q.ctrl[ULPW_CTRL_ERR_MASK]) |-> !rx_error_irq_o)
        else $error("error interrupt while masked");
    a_good_frame_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        out_valid && out_ready && !fr_out.pe && !fr_out.fe |=> rx_complete_irq_o)
        else $error("no completion for good frame");
endmodule // ulpw_wake_rx

// ---- verif/tb_top.sv ----
// Self-checking bench for the wake-on-receive serial receiver
`timescale 1ns/1ps
module tb_top;
    import ulpw_pkg::*;
    // Short bit time keeps the run brief: divisor 7, exponent 0 gives 8 cycles
    localparam int BIT = 8;
    localparam logic [31:0] WK = 32'h1 << ULPW_CTRL_WAKE_EN;
    localparam logic [31:0] MK = 32'h1 << ULPW_CTRL_ERR_MASK;
    localparam logic [31:0] IE = 32'h1 << ULPW_CTRL_ERR_IRQ_EN;
    localparam logic [31:0] ST = 32'h1 << ULPW_CTRL_CH1_START;
    localparam logic [31:0] PB = 32'h1 << ULPW_CTRL_PARITY_EN;
    logic clk_i, resetn_i, reg_wr_i, reg_rd_i, stop_mode_i, serial_rx_pin_i;
    logic rx_complete_irq_o, rx_error_irq_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    int n_errors, cmp_count, n_cpl, n_err, cyc, c0, e0;

    ulpw_wake_rx i_ulpw_wake_rx (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .stop_mode_i(stop_mode_i),
        .serial_rx_pin_i(serial_rx_pin_i), .rx_complete_irq_o(rx_complete_irq_o),
        .rx_error_irq_o(rx_error_irq_o));
    ulpw_tb_tx #(.BIT_CYC(BIT)) i_ulpw_tb_tx (.clk_i(clk_i), .tx_o(serial_rx_pin_i));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock stands for the fast internal oscillator, the only legal source
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Count event pulses and cut a hang short
    always @(posedge clk_i)
    begin
        cyc++;
        if (rx_complete_irq_o === 1'b1) n_cpl++;
        if (rx_error_irq_o === 1'b1) n_err++;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    // Send one frame, let it settle, then compare event counts
    task automatic frame(input logic [7:0] b, input logic ok, input int nc, input int ne);
        c0 = n_cpl;
        e0 = n_err;
        i_ulpw_tb_tx.send(b, ok);
        repeat (40) @(posedge clk_i);
        chk(n_cpl - c0, nc);
        chk(n_err - e0, ne);
    endtask
    // Same as frame, with an even parity bit after the data
    task automatic pframe(input logic [7:0] b, input logic ok, input int nc, input int ne);
        c0 = n_cpl;
        e0 = n_err;
        i_ulpw_tb_tx.send_par(b, ok);
        repeat (40) @(posedge clk_i);
        chk(n_cpl - c0, nc);
        chk(n_err - e0, ne);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(ULPW_OFF_BAUD, ULPW_BAUD_RESET);
        rd(ULPW_OFF_CHAN, {30'h0, ULPW_WAKE_CHANNEL});
        rd(ULPW_OFF_CTRL, 32'h0);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        wr(ULPW_OFF_BAUD, 32'h7 << ULPW_BAUD_DIV_LSB);
    endtask
    task automatic t_halt();
        wr(ULPW_OFF_CTRL, ST);
        stop_mode_i <= 1'b1;
        frame(8'h3c, 1'b1, 0, 0);
        stop_mode_i <= 1'b0;
    endtask
    task automatic t_wake();
        wr(ULPW_OFF_STAT, 32'h7);
        wr(ULPW_OFF_CTRL, WK | ST);
        stop_mode_i <= 1'b1;
        frame(8'h5a, 1'b1, 1, 0);
        stop_mode_i <= 1'b0;
        wr(ULPW_OFF_CTRL, ST);
        rd(ULPW_OFF_DATA, 32'h5a);
        rd(ULPW_OFF_STAT, 32'h0);
    endtask
    task automatic t_mask();
        wr(ULPW_OFF_CTRL, WK | MK | IE | ST);
        stop_mode_i <= 1'b1;
        frame(8'h81, 1'b0, 0, 0);
        stop_mode_i <= 1'b0;
        wr(ULPW_OFF_CTRL, IE | ST);
        rd(ULPW_OFF_STAT, 32'h10);
        rd(ULPW_OFF_DATA, 32'h81);
    endtask
    task automatic t_err();
        frame(8'h42, 1'b0, 0, 1);
        rd(ULPW_OFF_STAT, 32'h12);
        wr(ULPW_OFF_STAT, 32'h2);
        rd(ULPW_OFF_DATA, 32'h42);
        rd(ULPW_OFF_STAT, 32'h0);
    endtask
    // Wake armed but reception begun outside stop is flagged as corrupt
    task automatic t_early();
        wr(ULPW_OFF_CTRL, WK | IE | ST);
        frame(8'h66, 1'b1, 0, 1);
        rd(ULPW_OFF_STAT, 32'h12);
        wr(ULPW_OFF_STAT, 32'h2);
        rd(ULPW_OFF_DATA, 32'h66);
        wr(ULPW_OFF_CTRL, ST);
    endtask
    // Good parity completes; bad parity sets its flag and raises the error event
    task automatic t_parity();
        wr(ULPW_OFF_CTRL, PB | IE | ST);
        pframe(8'h37, 1'b1, 1, 0);
        rd(ULPW_OFF_DATA, 32'h37);
        pframe(8'h38, 1'b0, 0, 1);
        rd(ULPW_OFF_STAT, 32'h11);
        wr(ULPW_OFF_STAT, 32'h1);
        rd(ULPW_OFF_DATA, 32'h38);
        rd(ULPW_OFF_STAT, 32'h0);
    endtask
    // Mid-run reset returns baud, control and status to their reset values, overrun flag too
    task automatic t_rerst();
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(ULPW_OFF_BAUD, ULPW_BAUD_RESET);
        rd(ULPW_OFF_CTRL, 32'h0);
        rd(ULPW_OFF_STAT, 32'h0);
    endtask
    // Reader stalls while four frames arrive; the fourth finds no room
    task automatic t_fill();
        wr(ULPW_OFF_CTRL, ST);
        frame(8'h11, 1'b1, 1, 0);
        frame(8'h22, 1'b1, 0, 0);
        frame(8'h33, 1'b1, 0, 0);
        frame(8'h44, 1'b1, 0, 0);
        for (int i = 1; i < 4; i++)
        begin
            rd(ULPW_OFF_DATA, 32'h11 * i);
            repeat (5) @(posedge clk_i);
        end
        rd(ULPW_OFF_STAT, 32'h4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        resetn_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        stop_mode_i = 1'b0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_halt();
        t_wake();
        t_mask();
        t_err();
        t_early();
        t_parity();
        t_fill();
        t_rerst();
        test_done();
    end
endmodule // tb_top

// ---- verif/ulpw_tb_tx.sv ----
// Remote serial transmitter model driving the wake receiver's pin
`timescale 1ns/1ps
module ulpw_tb_tx #(
    parameter int BIT_CYC = 8
)
(
    // Clock
    input wire logic clk_i,
    // Serial line
    output logic tx_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Line idles high between frames so no false start edge is seen
    initial tx_o = 1'b1;
    // Start, 8 data bits LSB first, stop; a low stop bit makes a framing fault
    task automatic send(input logic [7:0] b, input logic stop_ok);
        send_bits({1'b1, stop_ok, b, 1'b0}, 10);
    endtask
    // Even parity bit after the data; a low par_ok sends the wrong one
    task automatic send_par(input logic [7:0] b, input logic par_ok);
        send_bits({1'b1, (^b) ^ !par_ok, b, 1'b0}, 11);
    endtask
    // Shift the first n bits of f out, LSB first, each bit BIT_CYC cycles long
    task automatic send_bits(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            tx_o <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        tx_o <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge clk_i);
    endtask
endmodule // ulpw_tb_tx
